// File: testbench/asf_host_model.sv
/*
 * Host model: issues the register reads and writes of the controlling host.
 * Assumes it shares clock_i with the status block; strobes last one cycle.
 */
`timescale 1ns/1ps
`default_nettype none

module asf_host_model (
   input  wire logic        clock_i,
   output logic      [7:0]  reg_addr_o,
   output logic      [15:0] reg_wdata_o,
   output logic             reg_wr_o,
   output logic             reg_rd_o,
   input  wire logic [15:0] reg_rdata_i
);
   initial begin
      reg_addr_o  = 8'h00;
      reg_wdata_o = 16'h0000;
      reg_wr_o    = 1'b0;
      reg_rd_o    = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // idle address and data are inverted so nothing can lean on stale values
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clock_i);
      reg_addr_o  <= a;
      reg_wdata_o <= d;
      reg_wr_o    <= 1'b1;
      @(posedge clock_i);
      reg_wr_o    <= 1'b0;
      reg_addr_o  <= ~a;
      reg_wdata_o <= ~d;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge clock_i);
      reg_addr_o <= a;
      reg_rd_o   <= 1'b1;
      @(posedge clock_i);
      reg_rd_o   <= 1'b0;
      reg_addr_o <= ~a;
      // data stand only in the cycle after the strobe: take them at its end
      @(posedge clock_i);
      d = reg_rdata_i;
   endtask : rd
endmodule : asf_host_model

`default_nettype wire

// File: testbench/asf_status_test.sv
/*
 * Self-checking bench for the axis status flag block.
 * Assumes the host model for register traffic; motion inputs driven here.
 */
`timescale 1ns/1ps
`default_nettype none

module asf_status_test;
   logic        clock_i, resetn_i, clk_en_i;
   logic [7:0]  reg_addr;
   logic [15:0] reg_wdata, reg_rdata;
   logic        reg_wr, reg_rd, irq;
   logic        servo_unlocked_i, decel_stop_req_i, imm_stop_req_i;
   logic        moving_i, devrst_nak_i, origin_search_i, manual_or_direct_i;
   logic        direct_op_i, halt_i, finish_i, interp_i, pass_pattern_i;
   logic [2:0]  axis_phase_i, path_phase_i;
   int          failures, checks_done;
   localparam logic [7:0] CMD = asf_pkg::IDX_CMD_STATUS;
   localparam logic [7:0] OPS = asf_pkg::IDX_OP_STATUS;
   localparam logic [7:0] IST = asf_pkg::IDX_IRQ_STATUS;

   asf_status i_dut (.clock_i(clock_i), .resetn_i(resetn_i),
      .clk_en_i(clk_en_i), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
      .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
      .irq_o(irq), .servo_unlocked_i(servo_unlocked_i),
      .decel_stop_req_i(decel_stop_req_i), .imm_stop_req_i(imm_stop_req_i),
      .moving_i(moving_i), .devrst_nak_i(devrst_nak_i),
      .origin_search_i(origin_search_i),
      .manual_or_direct_i(manual_or_direct_i), .direct_op_i(direct_op_i),
      .halt_i(halt_i), .finish_i(finish_i), .axis_phase_i(axis_phase_i),
      .path_phase_i(path_phase_i), .interp_i(interp_i),
      .pass_pattern_i(pass_pattern_i));

   asf_host_model i_host (.clock_i(clock_i), .reg_addr_o(reg_addr),
      .reg_wdata_o(reg_wdata), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd),
      .reg_rdata_i(reg_rdata));

   initial clock_i = 1'b0;
   always #25 clock_i = ~clock_i;

   ////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop();
      if (failures == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : report_and_stop

   task automatic check(input string nm, input logic [15:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   task automatic rc(input logic [7:0] a, input logic [15:0] e,
                     input string nm);
      logic [15:0] d;
      i_host.rd(a, d);
      check(nm, d, e);
   endtask : rc

   task automatic tick(input int n);
      repeat (n) @(posedge clock_i);
   endtask : tick

   ////////////////////////////////////////////////////////////////////////
   initial begin
      {resetn_i, servo_unlocked_i, decel_stop_req_i, imm_stop_req_i} = 4'h0;
      {moving_i, devrst_nak_i, origin_search_i, manual_or_direct_i} = 4'h0;
      {direct_op_i, halt_i, finish_i, interp_i, pass_pattern_i} = 5'h0;
      axis_phase_i = 3'h0;
      path_phase_i = 3'h0;
      clk_en_i = 1'b1;
      failures = 0;
      checks_done = 0;
      tick(4);
      resetn_i <= 1'b1;
      tick(4);
      rc(CMD, 16'h0000, "cmd_after_reset");
      rc(OPS, 16'h0002, "op_locked_at_rest");
      rc(8'h05, 16'h0000, "unmapped_read");
      servo_unlocked_i <= 1'b1;
      tick(6);
      rc(OPS, 16'h0001, "op_servo_unlocked");
      servo_unlocked_i <= 1'b0;
      moving_i <= 1'b1;
      pass_pattern_i <= 1'b1;
      for (int p = 1; p < 6; p++) begin
         axis_phase_i <= p[2:0];
         tick(3);
         rc(OPS, 16'(1 << (p + 2)), "op_axis_phase");
      end
      axis_phase_i <= asf_pkg::PH_PASS;
      pass_pattern_i <= 1'b0;
      tick(3);
      rc(OPS, 16'h0000, "op_pass_no_pattern");
      // axis code parked on decel so a wrong selection shows up
      axis_phase_i <= 3'h3;
      interp_i <= 1'b1;
      pass_pattern_i <= 1'b0;
      for (int p = 1; p < 6; p++) begin
         path_phase_i <= p[2:0];
         tick(3);
         rc(OPS, 16'(1 << (p + 2)), "op_path_phase");
      end
      {interp_i, axis_phase_i, path_phase_i} <= 7'h0;
      decel_stop_req_i <= 1'b1;
      tick(6);
      rc(OPS, 16'h0100, "op_decel_stop");
      imm_stop_req_i <= 1'b1;
      tick(6);
      rc(OPS, 16'h0200, "op_imm_stop");
      {moving_i, decel_stop_req_i, imm_stop_req_i} <= 3'h0;
      tick(6);
      rc(OPS, 16'h0002, "op_stop_ended");
      finish_i <= 1'b1;
      tick(1);
      finish_i <= 1'b0;
      tick(2);
      rc(CMD, 16'h0000, "cmd_finish_not_direct");
      {origin_search_i, devrst_nak_i} <= 2'h3;
      tick(1);
      {origin_search_i, devrst_nak_i} <= 2'h0;
      tick(2);
      rc(CMD, 16'h0200, "cmd_devrst_nak");
      {manual_or_direct_i, halt_i} <= 2'h3;
      tick(1);
      {manual_or_direct_i, halt_i} <= 2'h0;
      tick(2);
      rc(CMD, 16'h1200, "cmd_stop_done");
      {direct_op_i, finish_i} <= 2'h3;
      tick(1);
      {direct_op_i, finish_i} <= 2'h0;
      tick(2);
      rc(CMD, 16'h3200, "cmd_pos_done");
      check("irq_masked", {15'h0, irq}, 16'h0000);
      i_host.wr(asf_pkg::IDX_IRQ_MASK, 16'h0007);
      tick(1);
      check("irq_unmasked", {15'h0, irq}, 16'h0001);
      rc(IST, 16'h0007, "irq_status");
      tick(1);
      check("irq_after_read", {15'h0, irq}, 16'h0000);
      rc(IST, 16'h0000, "irq_status_cleared");
      rc(asf_pkg::IDX_IRQ_MASK, 16'h0007, "irq_mask");
      i_host.wr(CMD, 16'hFFFF);
      rc(CMD, 16'h3200, "cmd_write_ignored");
      i_host.wr(asf_pkg::IDX_CONTROL, 16'h0007);
      rc(CMD, 16'h0000, "cmd_cleared");
      // an event while the enable is low must leave no trace
      clk_en_i <= 1'b0;
      {direct_op_i, finish_i} <= 2'h3;
      tick(2);
      {direct_op_i, finish_i} <= 2'h0;
      clk_en_i <= 1'b1;
      tick(1);
      rc(CMD, 16'h0000, "cmd_frozen_by_enable");
      report_and_stop();
   end

   // the sequence needs well under 1000 cycles
   initial begin
      #(3000 * 50);
      failures++;
      report_and_stop();
   end
endmodule : asf_status_test

`default_nettype wire

// File: verilog/asf_phase_dec.sv
/*
 * Profile phase decoder: turns the motion engine phase code into the five
 * one-hot phase flags, choosing the path phase while interpolating.
 * Assumes phase inputs are from logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module asf_phase_dec (
   input  wire logic [2:0] axis_phase_i,
   input  wire logic [2:0] path_phase_i,
   input  wire logic       interp_i,
   input  wire logic       pass_pattern_i,
   output logic      [4:0] phase_flags_o
);

   logic [2:0] sel;

   always_comb begin
      // during interpolation the path profile is what software watches
      sel = interp_i ? path_phase_i : axis_phase_i;
      phase_flags_o = 5'h0;
      case (sel)
         asf_pkg::PH_ACCEL: phase_flags_o[0] = 1'b1;
         asf_pkg::PH_CONST: phase_flags_o[1] = 1'b1;
         asf_pkg::PH_DECEL: phase_flags_o[2] = 1'b1;
         asf_pkg::PH_PASS: begin
            phase_flags_o[3] = pass_pattern_i | interp_i;
         end
         asf_pkg::PH_WAIT:  phase_flags_o[4] = 1'b1;
         default:           phase_flags_o = 5'h0;
      endcase
   end

endmodule : asf_phase_dec

`default_nettype wire

// File: verilog/asf_pkg.sv
/*
 * Package for the axis status flag block: register indices, bit positions,
 * reset values and profile phase codes.
 * Assumes a 16-bit register port with word indices, byte address = 4*index.
 */
`default_nettype none

package asf_pkg;

   ////////////////////////////////////////////////////////////////////////
   // register indices (byte address is four times the index)
   localparam logic [7:0]  IDX_CMD_STATUS  = 8'h02;
   localparam logic [7:0]  IDX_OP_STATUS   = 8'h03;
   localparam logic [7:0]  IDX_IRQ_STATUS  = 8'h10;
   localparam logic [7:0]  IDX_IRQ_MASK    = 8'h11;
   localparam logic [7:0]  IDX_CONTROL     = 8'h12;

   ////////////////////////////////////////////////////////////////////////
   // command status bits
   localparam int CMD_DEVRST_NAK   = 9;
   localparam int CMD_STOP_DONE    = 12;
   localparam int CMD_POS_DONE     = 13;

   // operation status bits
   localparam int OP_SERVO_OFF     = 0;
   localparam int OP_SERVO_LOCK    = 1;
   localparam int OP_ACCEL         = 3;
   localparam int OP_CONST         = 4;
   localparam int OP_DECEL         = 5;
   localparam int OP_PASS          = 6;
   localparam int OP_WAIT_DONE     = 7;
   localparam int OP_DECEL_STOP    = 8;
   localparam int OP_IMM_STOP      = 9;

   // used-bit masks, all other bits read zero
   localparam logic [15:0] CMD_USED_MASK   = 16'h3200;
   localparam logic [15:0] OP_USED_MASK    = 16'h03FB;

   // interrupt status bits
   localparam int IRQ_DEVRST_NAK   = 0;
   localparam int IRQ_STOP_DONE    = 1;
   localparam int IRQ_POS_DONE     = 2;
   localparam int IRQ_WIDTH        = 3;

   // control register bits
   localparam int CTL_CLR_NAK      = 0;
   localparam int CTL_CLR_STOP     = 1;
   localparam int CTL_CLR_POS      = 2;

   ////////////////////////////////////////////////////////////////////////
   // reset values
   localparam logic [15:0] RST_ZERO16      = 16'h0000;
   localparam logic [2:0]  RST_IRQ_MASK    = 3'h0;

   // profile phase codes from the motion engine
   localparam logic [2:0]  PH_IDLE  = 3'h0;
   localparam logic [2:0]  PH_ACCEL = 3'h1;
   localparam logic [2:0]  PH_CONST = 3'h2;
   localparam logic [2:0]  PH_DECEL = 3'h3;
   localparam logic [2:0]  PH_PASS  = 3'h4;
   localparam logic [2:0]  PH_WAIT  = 3'h5;

   typedef enum logic [2:0] {
      ASF_ST_IDLE = 3'b001,
      ASF_ST_DEC  = 3'b010,
      ASF_ST_IMM  = 3'b100
   } asf_stop_e;

endpackage : asf_pkg

`default_nettype wire

// File: verilog/asf_status.sv
/*
 * Axis status flag logic: command status upper flags, operation status word,
 * sticky interrupt status with mask, and the register port.
 * Assumes motion engine inputs are on clock_i; servo and stop request
 * inputs from the outside pins are synchronised here.
 */
// Strobed register access was decided locally.
`timescale 1ns/1ps
`default_nettype none

module asf_status (
   input  wire logic        clock_i,
   input  wire logic        resetn_i,
   input  wire logic        clk_en_i,
   // register port
   input  wire logic [7:0]  reg_addr_i,
   input  wire logic [15:0] reg_wdata_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   output logic      [15:0] reg_rdata_o,
   output logic             irq_o,
   // outside pins
   input  wire logic        servo_unlocked_i,
   input  wire logic        decel_stop_req_i,
   input  wire logic        imm_stop_req_i,
   // motion engine events
   input  wire logic        moving_i,
   input  wire logic        devrst_nak_i,
   input  wire logic        origin_search_i,
   input  wire logic        manual_or_direct_i,
   input  wire logic        direct_op_i,
   input  wire logic        halt_i,
   input  wire logic        finish_i,
   input  wire logic [2:0]  axis_phase_i,
   input  wire logic [2:0]  path_phase_i,
   input  wire logic        interp_i,
   input  wire logic        pass_pattern_i
);

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   logic [2:0] sync1_r;
   logic [2:0] sync2_r;
   logic [2:0] sync1_nxt;
   logic [2:0] sync2_nxt;
   logic       servo_off;
   logic       dec_req;
   logic       imm_req;

   always_comb begin
      sync1_nxt = {imm_stop_req_i, decel_stop_req_i, servo_unlocked_i};
      sync2_nxt = sync1_r;
   end

   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sync1_r <= 3'h0;
         sync2_r <= 3'h0;
      end else if (clk_en_i) begin
         sync1_r <= sync1_nxt;
         sync2_r <= sync2_nxt;
      end
   end

   assign servo_off = sync2_r[0];
   assign dec_req   = sync2_r[1];
   assign imm_req   = sync2_r[2];

   ////////////////////////////////////////////////////////////////////////
   // stop tracking: an immediate request overrides a deceleration stop
   asf_pkg::asf_stop_e stop_r;
   asf_pkg::asf_stop_e stop_nxt;

   always_comb begin
      stop_nxt = stop_r;
      case (stop_r)
         asf_pkg::ASF_ST_IDLE: begin
            if (imm_req && moving_i) begin
               stop_nxt = asf_pkg::ASF_ST_IMM;
            end else if (dec_req && moving_i) begin
               stop_nxt = asf_pkg::ASF_ST_DEC;
            end
         end
         asf_pkg::ASF_ST_DEC: begin
            if (!moving_i) begin
               stop_nxt = asf_pkg::ASF_ST_IDLE;
            end else if (imm_req) begin
               stop_nxt = asf_pkg::ASF_ST_IMM;
            end
         end
         asf_pkg::ASF_ST_IMM: begin
            if (!moving_i) begin
               stop_nxt = asf_pkg::ASF_ST_IDLE;
            end
         end
         default: stop_nxt = asf_pkg::ASF_ST_IDLE;
      endcase
   end

   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         stop_r <= asf_pkg::ASF_ST_IDLE;
      end else if (clk_en_i) begin
         stop_r <= stop_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // phase flags
   logic [4:0] phase_flags;

   asf_phase_dec u_phase (
      .axis_phase_i   (axis_phase_i),
      .path_phase_i   (path_phase_i),
      .interp_i       (interp_i),
      .pass_pattern_i (pass_pattern_i),
      .phase_flags_o  (phase_flags)
   );

   ////////////////////////////////////////////////////////////////////////
   // command status flags, operation status word, interrupts
   logic [15:0] cmd_r;
   logic [15:0] cmd_nxt;
   logic [15:0] op_r;
   logic [15:0] op_nxt;
   logic [2:0]  ists_r;
   logic [2:0]  ists_nxt;
   logic [2:0]  imask_r;
   logic [2:0]  imask_nxt;
   logic [15:0] rdata_r;
   logic [15:0] rdata_nxt;
   logic [2:0]  ev;
   logic [2:0]  clr;
   logic        wr_ctl;

   always_comb begin
      ev[asf_pkg::IRQ_DEVRST_NAK] = devrst_nak_i & origin_search_i;
      ev[asf_pkg::IRQ_STOP_DONE]  = halt_i & manual_or_direct_i;
      ev[asf_pkg::IRQ_POS_DONE]   = finish_i & direct_op_i;
      wr_ctl = reg_wr_i && (reg_addr_i == asf_pkg::IDX_CONTROL);
      clr = 3'h0;
      if (wr_ctl) begin
         clr = reg_wdata_i[2:0];
      end

      // flags stay on until software clears them; a new event wins
      cmd_nxt = cmd_r;
      cmd_nxt[asf_pkg::CMD_DEVRST_NAK] = ev[asf_pkg::IRQ_DEVRST_NAK] |
         (cmd_r[asf_pkg::CMD_DEVRST_NAK] & ~clr[asf_pkg::CTL_CLR_NAK]);
      cmd_nxt[asf_pkg::CMD_STOP_DONE] = ev[asf_pkg::IRQ_STOP_DONE] |
         (cmd_r[asf_pkg::CMD_STOP_DONE] & ~clr[asf_pkg::CTL_CLR_STOP]);
      cmd_nxt[asf_pkg::CMD_POS_DONE] = ev[asf_pkg::IRQ_POS_DONE] |
         (cmd_r[asf_pkg::CMD_POS_DONE] & ~clr[asf_pkg::CTL_CLR_POS]);
      cmd_nxt = cmd_nxt & asf_pkg::CMD_USED_MASK;

      op_nxt = asf_pkg::RST_ZERO16;
      op_nxt[asf_pkg::OP_SERVO_OFF]  = servo_off;
      op_nxt[asf_pkg::OP_SERVO_LOCK] = ~servo_off & ~moving_i;
      op_nxt[asf_pkg::OP_ACCEL]      = phase_flags[0];
      op_nxt[asf_pkg::OP_CONST]      = phase_flags[1];
      op_nxt[asf_pkg::OP_DECEL]      = phase_flags[2];
      op_nxt[asf_pkg::OP_PASS]       = phase_flags[3];
      op_nxt[asf_pkg::OP_WAIT_DONE]  = phase_flags[4];
      op_nxt[asf_pkg::OP_DECEL_STOP] = (stop_r == asf_pkg::ASF_ST_DEC);
      op_nxt[asf_pkg::OP_IMM_STOP]   = (stop_r == asf_pkg::ASF_ST_IMM);
      op_nxt = op_nxt & asf_pkg::OP_USED_MASK;

      // read clears the interrupt status, an event in the same cycle survives
      ists_nxt = ists_r;
      if (reg_rd_i && (reg_addr_i == asf_pkg::IDX_IRQ_STATUS)) begin
         ists_nxt = 3'h0;
      end
      ists_nxt = ists_nxt | ev;

      imask_nxt = imask_r;
      if (reg_wr_i && (reg_addr_i == asf_pkg::IDX_IRQ_MASK)) begin
         imask_nxt = reg_wdata_i[2:0];
      end

      rdata_nxt = asf_pkg::RST_ZERO16;
      if (reg_rd_i) begin
         if (reg_addr_i == asf_pkg::IDX_CMD_STATUS) begin
            rdata_nxt = cmd_r;
         end else if (reg_addr_i == asf_pkg::IDX_OP_STATUS) begin
            rdata_nxt = op_r;
         end else if (reg_addr_i == asf_pkg::IDX_IRQ_STATUS) begin
            rdata_nxt = {13'h0, ists_r};
         end else if (reg_addr_i == asf_pkg::IDX_IRQ_MASK) begin
            rdata_nxt = {13'h0, imask_r};
         end else begin
            rdata_nxt = asf_pkg::RST_ZERO16;
         end
      end
   end

   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cmd_r   <= asf_pkg::RST_ZERO16;
         op_r    <= asf_pkg::RST_ZERO16;
         ists_r  <= 3'h0;
         imask_r <= asf_pkg::RST_IRQ_MASK;
         rdata_r <= asf_pkg::RST_ZERO16;
      end else if (clk_en_i) begin
         cmd_r   <= cmd_nxt;
         op_r    <= op_nxt;
         ists_r  <= ists_nxt;
         imask_r <= imask_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   assign reg_rdata_o = rdata_r;
   assign irq_o       = |(ists_r & imask_r);

   ////////////////////////////////////////////////////////////////////////
   // checks
   a_nak_sets: assert property (
      @(posedge clock_i) disable iff (!resetn_i)
      clk_en_i && devrst_nak_i && origin_search_i
      |=> cmd_r[asf_pkg::CMD_DEVRST_NAK])
      else $error("deviation reset flag not set");
   a_stop_done_sets: assert property (
      @(posedge clock_i) disable iff (!resetn_i)
      clk_en_i && halt_i && manual_or_direct_i
      |=> cmd_r[asf_pkg::CMD_STOP_DONE] && ists_r[asf_pkg::IRQ_STOP_DONE])
      else $error("stop executed flag not set");
   a_pos_done_sets: assert property (
      @(posedge clock_i) disable iff (!resetn_i)
      clk_en_i && finish_i && direct_op_i
      |=> cmd_r[asf_pkg::CMD_POS_DONE])
      else $error("positioning completed flag not set");
   a_servo_off_flag: assert property (
      @(posedge clock_i) disable iff (!resetn_i)
      clk_en_i |=> op_r[asf_pkg::OP_SERVO_OFF] == $past(servo_off))
      else $error("servo unlocked flag wrong");
   a_servo_lock_flag: assert property (
      @(posedge clock_i) disable iff (!resetn_i)
      op_r[asf_pkg::OP_SERVO_LOCK] |-> !op_r[asf_pkg::OP_SERVO_OFF])
      else $error("servo locked and unlocked together");
   a_servo_lock_rest: assert property (
      @(posedge clock_i) disable iff (!resetn_i)
      clk_en_i |=> op_r[asf_pkg::OP_SERVO_LOCK] ==
         (!$past(servo_off) && !$past(moving_i)))
      else $error("servo locked flag wrong at rest");
   a_phase_onehot: assert property (
      @(posedge clock_i) disable iff (!resetn_i)
      $onehot0(op_r[7:3]))
      else $error("more than one profile phase flag");
   a_accel_flag: assert property (
      @(posedge clock_i) disable iff (!resetn_i)
      clk_en_i && !interp_i && axis_phase_i == asf_pkg::PH_ACCEL
      |=> op_r[asf_pkg::OP_ACCEL])
      else $error("acceleration flag not set");
   a_pass_gated: assert property (
      @(posedge clock_i) disable iff (!resetn_i)
      clk_en_i && !interp_i && !pass_pattern_i
      |=> !op_r[asf_pkg::OP_PASS])
      else $error("pass flag outside continuous pattern");
   a_wait_flag: assert property (
      @(posedge clock_i) disable iff (!resetn_i)
      clk_en_i && !interp_i && axis_phase_i == asf_pkg::PH_WAIT
      |=> op_r[asf_pkg::OP_WAIT_DONE])
      else $error("completion wait flag not set");
   a_interp_path: assert property (
      @(posedge clock_i) disable iff (!resetn_i)
      clk_en_i && interp_i && path_phase_i == asf_pkg::PH_CONST
      |=> op_r[asf_pkg::OP_CONST])
      else $error("path phase not shown");
   a_dec_stop_start: assert property (
      @(posedge clock_i) disable iff (!resetn_i)
      clk_en_i && stop_r == asf_pkg::ASF_ST_IDLE && moving_i && dec_req
      && !imm_req |=> stop_r == asf_pkg::ASF_ST_DEC)
      else $error("deceleration stop not started");
   a_dec_stop_hold: assert property (
      @(posedge clock_i) disable iff (!resetn_i)
      clk_en_i && stop_r == asf_pkg::ASF_ST_DEC && moving_i && !imm_req
      |=> op_r[asf_pkg::OP_DECEL_STOP])
      else $error("deceleration stop flag dropped");
   a_imm_stop_end: assert property (
      @(posedge clock_i) disable iff (!resetn_i)
      clk_en_i && stop_r == asf_pkg::ASF_ST_IMM && !moving_i
      |=> stop_r == asf_pkg::ASF_ST_IDLE)
      else $error("immediate stop not ended at rest");
   a_unused_zero: assert property (
      @(posedge clock_i) disable iff (!resetn_i)
      (cmd_r & ~asf_pkg::CMD_USED_MASK) == 16'h0000 &&
      (op_r & ~asf_pkg::OP_USED_MASK) == 16'h0000)
      else $error("unused status bit set");
   // a low enable must freeze flags even while events keep arriving
   a_enable_freeze: assert property (
      @(posedge clock_i) disable iff (!resetn_i)
      !clk_en_i |=> $stable(cmd_r) && $stable(op_r) && $stable(ists_r))
      else $error("state moved while enable low");
   a_read_clear: assert property (
      @(posedge clock_i) disable iff (!resetn_i)
      clk_en_i && reg_rd_i && reg_addr_i == asf_pkg::IDX_IRQ_STATUS &&
      ev == 3'h0 |=> ists_r == 3'h0)
      else $error("interrupt status not cleared by read");

   c_irq: cover property (@(posedge clock_i) disable iff (!resetn_i) irq_o);
   c_imm: cover property (@(posedge clock_i) disable iff (!resetn_i)
      stop_r == asf_pkg::ASF_ST_IMM);
   c_dec: cover property (@(posedge clock_i) disable iff (!resetn_i)
      stop_r == asf_pkg::ASF_ST_DEC ##1 stop_r == asf_pkg::ASF_ST_IDLE);
   c_pass: cover property (@(posedge clock_i) disable iff (!resetn_i)
      op_r[asf_pkg::OP_PASS]);

endmodule : asf_status

`default_nettype wire
